// *** rtl/dds_regs.svh ***
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

// register byte offsets
`define DDS_ADDR_CTRL      8'h00
`define DDS_ADDR_DAC_A     8'h04
`define DDS_ADDR_DAC_B     8'h08
`define DDS_ADDR_STAGE     8'h0C
`define DDS_ADDR_CFG       8'h10
`define DDS_ADDR_STATUS    8'h14
`define DDS_ADDR_WORDS     8'h18

// reset values
`define DDS_CTRL_RESET     1'h1
// shift clock rests high between frames; a low reset value would fake a rise
`define DDS_LINK_IDLE      3'h6

// serial word
`define DDS_LAST_BIT       5'h0F
`define DDS_CNT_STEP       5'h01

// target select codes {target_select_high, target_select_low}
`define DDS_TGT_DACB_STAGE 2'h0
`define DDS_TGT_STAGE      2'h1
`define DDS_TGT_DACA       2'h2
`define DDS_TGT_CTRL       2'h3

// voltage source codes
`define DDS_REF_CODE_EXT0  2'h0
`define DDS_REF_CODE_LOW   2'h1
`define DDS_REF_CODE_HIGH  2'h2
`define DDS_REF_CODE_EXT3  2'h3

// bus responses
`define DDS_RESP_OKAY      2'h0
`define DDS_RESP_SLVERR    2'h2

`endif

// *** rtl/dds_pkg.sv ***
package dds_pkg;

  typedef enum logic [1:0] {
    DDS_REF_EXT,
    DDS_REF_INT_LOW,
    DDS_REF_INT_HIGH
  } dds_ref_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } dds_link_t;

  typedef struct packed {
    logic       target_select_high;
    logic       speed_select_bit;
    logic       power_down_bit;
    logic       target_select_low;
    logic [9:0] value;
    logic       voltage_source_code_high;
    logic       voltage_source_code_low;
  } dds_word_t;

  typedef struct packed {
    dds_ref_t   ref_src;
    logic [1:0] ref_code;
    logic       power_down;
    logic       speed_fast;
  } dds_cfg_t;

  typedef struct packed {
    logic       pending;
    logic [4:0] bit_cnt;
    logic       frame_active;
  } dds_stat_t;

endpackage

// *** rtl/dds_top.sv ***
// Contract
// - select low, msb first, one bit sampled per falling shift clock edge.
// - sixteen bits or early select rise moves the word into its target latch.
// - target code 10 writes dac a and moves staging into dac b.
// - voltage code 00/11 external, 01 lower internal, 10 higher internal.
// - control word with low bits 01 selects the lower internal level.
// - staging-only word stores the value and leaves both outputs alone.
// - staging load then dac a word updates both outputs together.
// - both outputs change at the rising clock edge after the last bit.
// - any word with the power bit set forces power down.
// - speed bit zero selects slow mode, one selects fast mode.
`include "dds_regs.svh"

module dds_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire dds_pkg::dds_link_t link_i,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [9:0]              dac_a,
  output logic [9:0]              dac_b,
  output logic                    speed_fast,
  output logic                    power_down,
  output dds_pkg::dds_ref_t       ref_src
);
  import dds_pkg::*;

  if (ADDR_W < 8)
  begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  dds_link_t   sync1_q;
  dds_link_t   sync2_q;
  dds_link_t   prev_q;
  logic [15:0] shreg_q;
  logic [4:0]  bit_cnt_q;
  logic [4:0]  cnt_base;
  logic        pending_q;
  logic [9:0]  dac_a_q;
  logic [9:0]  dac_b_q;
  logic [9:0]  stage_q;
  logic [1:0]  ref_code_q;
  dds_ref_t    ref_src_q;
  logic        speed_q;
  logic        pwr_q;
  logic        link_en_q;
  logic [15:0] words_q;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        shift_w;
  logic        commit_w;
  dds_word_t   word_w;
  logic [1:0]  tgt_w;
  dds_cfg_t    cfg_w;
  dds_stat_t   stat_w;

  // pins are asynchronous to aclk: two stages, then a third for edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= `DDS_LINK_IDLE;
      sync2_q <= `DDS_LINK_IDLE;
      prev_q  <= `DDS_LINK_IDLE;
    end
    else if (ce)
    begin
      sync1_q <= link_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign sclk_fall = prev_q.sclk & ~sync2_q.sclk;
  assign sclk_rise = ~prev_q.sclk & sync2_q.sclk;
  assign cs_fall   = prev_q.cs_n & ~sync2_q.cs_n;
  assign cs_rise   = ~prev_q.cs_n & sync2_q.cs_n;

  // a full word waits for the next rising edge; extra bits before it are dropped
  assign shift_w  = ce & link_en_q & ~sync2_q.cs_n & sclk_fall & ~pending_q;
  assign commit_w = ce & link_en_q & ((pending_q & sclk_rise)
                  | (cs_rise & (pending_q | (bit_cnt_q != '0))));
  assign cnt_base = cs_fall ? '0 : bit_cnt_q;
  assign word_w   = dds_word_t'(shreg_q);
  assign tgt_w    = {word_w.target_select_high, word_w.target_select_low};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shreg_q   <= '0;
      bit_cnt_q <= '0;
      pending_q <= 1'b0;
    end
    else if (ce)
    begin
      if (commit_w)
      begin
        bit_cnt_q <= '0;
        pending_q <= 1'b0;
      end
      else if (shift_w)
      begin
        shreg_q   <= {shreg_q[14:0], sync2_q.din};
        bit_cnt_q <= cnt_base + `DDS_CNT_STEP;
        pending_q <= (cnt_base == `DDS_LAST_BIT);
      end
      else if (cs_fall)
      begin
        bit_cnt_q <= '0;
        pending_q <= 1'b0;
      end
    end
  end

  // output latches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dac_a_q <= '0;
      dac_b_q <= '0;
      stage_q <= '0;
    end
    else if (commit_w)
    begin
      case (tgt_w)
        `DDS_TGT_DACB_STAGE:
        begin
          dac_b_q <= word_w.value;
          stage_q <= word_w.value;
        end
        `DDS_TGT_STAGE:
        begin
          stage_q <= word_w.value;
        end
        `DDS_TGT_DACA:
        begin
          dac_a_q <= word_w.value;
          dac_b_q <= stage_q;
        end
        default:
        begin
        end
      endcase
    end
  end

  // speed and power come with every word, whatever its target
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      speed_q    <= 1'b0;
      pwr_q      <= 1'b0;
      ref_code_q <= `DDS_REF_CODE_EXT0;
      ref_src_q  <= DDS_REF_EXT;
    end
    else if (commit_w)
    begin
      speed_q <= word_w.speed_select_bit;
      pwr_q   <= word_w.power_down_bit;
      if (tgt_w == `DDS_TGT_CTRL)
      begin
        ref_code_q <= {word_w.voltage_source_code_high, word_w.voltage_source_code_low};
        case ({word_w.voltage_source_code_high, word_w.voltage_source_code_low})
          `DDS_REF_CODE_LOW:  ref_src_q <= DDS_REF_INT_LOW;
          `DDS_REF_CODE_HIGH: ref_src_q <= DDS_REF_INT_HIGH;
          default:            ref_src_q <= DDS_REF_EXT;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      words_q <= '0;
    else if (commit_w)
      words_q <= words_q + 16'h0001;
  end

  assign dac_a      = dac_a_q;
  assign dac_b      = dac_b_q;
  assign speed_fast = speed_q;
  assign power_down = pwr_q;
  assign ref_src    = ref_src_q;
  assign cfg_w      = '{ref_src: ref_src_q, ref_code: ref_code_q,
                        power_down: pwr_q, speed_fast: speed_q};
  assign stat_w     = '{pending: pending_q, bit_cnt: bit_cnt_q,
                        frame_active: ~sync2_q.cs_n};

  // bus slave: one write and one read in flight, address and data in any order
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;
  logic [7:0] waddr_w;
  logic [7:0] raddr_w;
  logic [31:0] wdata_q;
  logic       wstrb0_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic       wr_go;

  assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go         = ce & aw_got_q & w_got_q & ~bvalid_q;
  assign waddr_w       = {awaddr_q[7:2], 2'h0};
  assign raddr_w       = {s_axi_araddr[7:2], 2'h0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DDS_RESP_OKAY;
      link_en_q <= `DDS_CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        // latches are read-only; only the enable bit takes writes
        if (waddr_w == `DDS_ADDR_CTRL && wstrb0_q)
          link_en_q <= wdata_q[0];
        if (waddr_w > `DDS_ADDR_WORDS)
          bresp_q <= `DDS_RESP_SLVERR;
        else
          bresp_q <= `DDS_RESP_OKAY;
      end
      else if (bvalid_q & s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `DDS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= `DDS_RESP_OKAY;
        case (raddr_w)
          `DDS_ADDR_CTRL:   rdata_q <= 32'(link_en_q);
          `DDS_ADDR_DAC_A:  rdata_q <= 32'(dac_a_q);
          `DDS_ADDR_DAC_B:  rdata_q <= 32'(dac_b_q);
          `DDS_ADDR_STAGE:  rdata_q <= 32'(stage_q);
          `DDS_ADDR_CFG:    rdata_q <= 32'(cfg_w);
          `DDS_ADDR_STATUS: rdata_q <= 32'(stat_w);
          `DDS_ADDR_WORDS:  rdata_q <= 32'(words_q);
          default:
          begin
            rdata_q <= '0;
            rresp_q <= `DDS_RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid_q & s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_shift_msb_first: assert property (shift_w
      |=> shreg_q == {$past(shreg_q[14:0]), $past(sync2_q.din)})
    else $error("shift register did not take the bit msb first");
  a_full_word_commit: assert property (ce && link_en_q && pending_q && sclk_rise
      |=> !pending_q && bit_cnt_q == '0 && words_q == $past(words_q) + 16'h0001)
    else $error("sixteen-bit word not committed on rising edge");
  a_early_commit: assert property (ce && link_en_q && cs_rise && bit_cnt_q != '0
      |=> bit_cnt_q == '0 && words_q == $past(words_q) + 16'h0001)
    else $error("partial word not committed on select rise");
  a_dac_a_pair: assert property (commit_w && tgt_w == `DDS_TGT_DACA
      |=> dac_a_q == $past(word_w.value) && dac_b_q == $past(stage_q))
    else $error("dac a word did not update both outputs");
  a_ref_ext_codes: assert property (ref_src_q == DDS_REF_EXT
      |-> ref_code_q == `DDS_REF_CODE_EXT0 || ref_code_q == `DDS_REF_CODE_EXT3)
    else $error("external reference with an internal code");
  a_ref_low_select: assert property (commit_w && tgt_w == `DDS_TGT_CTRL
      && word_w.voltage_source_code_high == 1'b0 && word_w.voltage_source_code_low == 1'b1
      |=> ref_src_q == DDS_REF_INT_LOW)
    else $error("code 01 did not select lower internal level");
  a_stage_only: assert property (commit_w && tgt_w == `DDS_TGT_STAGE
      |=> $stable(dac_a_q) && $stable(dac_b_q) && stage_q == $past(word_w.value))
    else $error("staging word disturbed an output");
  a_update_on_rise: assert property (ce && link_en_q && pending_q && sclk_rise
      && tgt_w == `DDS_TGT_DACA |=> dac_a_q == $past(word_w.value))
    else $error("dac a not updated at the rising edge after the last bit");
  a_power_bit: assert property (commit_w && word_w.power_down_bit |=> pwr_q)
    else $error("power bit did not force power down");
  a_speed_bit: assert property (commit_w |=> speed_q == $past(word_w.speed_select_bit))
    else $error("speed mode does not follow the speed bit");
  a_reset_clear: assert property ($past(aresetn) == 1'b0
      |-> dac_a_q == '0 && dac_b_q == '0 && stage_q == '0 && ref_code_q == '0)
    else $error("latches not cleared by reset");

  c_dual_update: cover property (commit_w && tgt_w == `DDS_TGT_DACA && stage_q != dac_b_q);
  c_power_down: cover property (commit_w && word_w.power_down_bit);
  c_early_select: cover property (commit_w && !pending_q);
  c_ref_high: cover property (commit_w && tgt_w == `DDS_TGT_CTRL
      && word_w.voltage_source_code_high && !word_w.voltage_source_code_low);

endmodule

// *** bench/dds_host_model.sv ***
module dds_host_model (
  output dds_pkg::dds_link_t link
);
  timeunit 1ns;
  timeprecision 1ns;
  import dds_pkg::*;

  // sclk rests high outside frames so the first edge seen in a frame is a fall
  initial link = '{cs_n: 1'h1, sclk: 1'h1, din: 1'h0};

  task automatic send(input logic [15:0] w, input int n, input int hold);
    // keep pin changes off the aclk edges
    #5;
    link.cs_n = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      link.din  = w[15-i];
      #80;
      link.sclk = 1'h0;
      #((i == 15) ? hold : 80);
      link.sclk = 1'h1;
    end
    #160;
    link.cs_n = 1'h1;
    // released line must not keep showing the last bit
    link.din  = ~link.din;
  endtask
endmodule

// *** bench/dual_dac_serial_command_bench.sv ***
`include "dds_regs.svh"

module dual_dac_serial_command_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dds_pkg::*;

  logic        aclk    = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, speed_fast, power_down;
  logic [1:0]  bresp, rresp, code;
  logic [31:0] rdata;
  logic [9:0]  dac_a, dac_b;
  dds_ref_t    ref_src, xr;
  dds_link_t   link;
  int          checks = 0;
  int          num_errors = 0;
  int          cycles = 0;

  always #10 aclk = ~aclk;

  dds_host_model host (.link(link));

  dds_top uut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .link_i(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dac_a(dac_a), .dac_b(dac_b),
    .speed_fast(speed_fast), .power_down(power_down), .ref_src(ref_src)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic outs(input logic [9:0] a, b, input logic s, p, input dds_ref_t r);
    chk("dac_a", {22'h0, a}, {22'h0, dac_a});
    chk("dac_b", {22'h0, b}, {22'h0, dac_b});
    chk("speed_fast", {31'h0, s}, {31'h0, speed_fast});
    chk("power_down", {31'h0, p}, {31'h0, power_down});
    chk("ref_src", {30'h0, r}, {30'h0, ref_src});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w  = 1'h0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (awvalid && awready) aw = 1'h1;
      if (wvalid && wready) w = 1'h1;
      awvalid <= !aw;
      wvalid  <= !w;
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    chk("bresp", {30'h0, r}, {30'h0, bresp});
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    chk("rdata", d, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  // outputs settle 3 aclk edges after the final sclk rise
  task automatic xmit(input logic [15:0] w, input int n);
    host.send(w, n, 80);
    repeat (8) @(posedge aclk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run needs about 1900 cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    outs(10'h0, 10'h0, 1'h0, 1'h0, DDS_REF_EXT);
    rd(`DDS_ADDR_CFG, 32'h0, `DDS_RESP_OKAY);
    rd(`DDS_ADDR_CTRL, 32'h1, `DDS_RESP_OKAY);
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      code = c[1:0];
      xr = (code == 2'h1) ? DDS_REF_INT_LOW : (code == 2'h2) ? DDS_REF_INT_HIGH : DDS_REF_EXT;
      xmit({1'h1, code[0], 1'h0, 1'h1, 10'h0, code}, 16);
      outs(10'h0, 10'h0, code[0], 1'h0, xr);
      rd(`DDS_ADDR_CFG, {26'h0, xr, code, 1'h0, code[0]}, `DDS_RESP_OKAY);
    end
    $display("test control done");
    xmit(16'h1554, 16);
    outs(10'h0, 10'h0, 1'h0, 1'h0, DDS_REF_EXT);
    rd(`DDS_ADDR_STAGE, 32'h155, `DDS_RESP_OKAY);
    fork
      host.send(16'hCB00, 16, 400);
      begin
        repeat (16) @(negedge link.sclk);
        #300;
        chk("early dac_a", 32'h0, {22'h0, dac_a});
        chk("early dac_b", 32'h0, {22'h0, dac_b});
      end
    join
    repeat (8) @(posedge aclk);
    outs(10'h2C0, 10'h155, 1'h1, 1'h0, DDS_REF_EXT);
    $display("test simultaneous done");
    for (int t = 0; t < 4; t++)
    begin
      code = t[1:0];
      xmit({code[1], 1'h0, 1'h1, code[0], 12'h0}, 16);
      chk("power_down", 32'h1, {31'h0, power_down});
    end
    xmit(16'hB400, 8);
    outs(10'h0, 10'h02D, 1'h0, 1'h0, DDS_REF_EXT);
    $display("test power and partial done");
    wr(`DDS_ADDR_CTRL, 32'h0, `DDS_RESP_OKAY);
    xmit(16'h83FC, 16);
    chk("disabled dac_a", 32'h0, {22'h0, dac_a});
    wr(`DDS_ADDR_CTRL, 32'h1, `DDS_RESP_OKAY);
    rd(`DDS_ADDR_CTRL, 32'h1, `DDS_RESP_OKAY);
    wr(8'h1C, 32'h1, `DDS_RESP_SLVERR);
    rd(8'h20, 32'h0, `DDS_RESP_SLVERR);
    wr(`DDS_ADDR_DAC_A, 32'h3FF, `DDS_RESP_OKAY);
    rd(`DDS_ADDR_DAC_A, 32'h0, `DDS_RESP_OKAY);
    xmit(16'h83FC, 16);
    outs(10'h0FF, 10'h02D, 1'h0, 1'h0, DDS_REF_EXT);
    rd(`DDS_ADDR_DAC_B, 32'h02D, `DDS_RESP_OKAY);
    rd(`DDS_ADDR_WORDS, 32'hC, `DDS_RESP_OKAY);
    rd(`DDS_ADDR_STATUS, 32'h0, `DDS_RESP_OKAY);
    $display("test registers done");
    finish_test();
  end
endmodule
